// File: asbc_pkg.sv
// package: types and timing constants for the static memory host controller
`default_nettype none
package asbc_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int CLK_NS = 50;
    // device timing figures in ns
    localparam int T_ACCESS_NS = 55;
    localparam int T_WRITE_PULSE_NS = 40;
    localparam int T_DATA_SETUP_NS = 25;
    localparam int T_STROBE_LOW_TO_FLOAT_NS = 20;
    localparam int T_OE_FLOAT_NS = 20;
    // least times round up, at least one cycle
    // two extra cycles: read data passes the two-flop synchroniser
    localparam int RD_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS + 2;
    localparam int WP_SUM_NS = T_DATA_SETUP_NS + T_STROBE_LOW_TO_FLOAT_NS;
    localparam int WP_NS = (T_WRITE_PULSE_NS > WP_SUM_NS) ?
        T_WRITE_PULSE_NS : WP_SUM_NS;
    localparam int WR_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int FLT_CYC = (T_STROBE_LOW_TO_FLOAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int OEF_CYC = (T_OE_FLOAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    typedef struct packed {
        logic select_active_low;
        logic select_active_high;
        logic write_strobe_n;
        logic output_enable_n;
    } asbc_ctl_t;

    localparam asbc_ctl_t CTL_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1};

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asbc_req_t;
endpackage : asbc_pkg
`default_nettype wire

// File: asbc_host.sv
// host controller driving an asynchronous static memory through its pins
`default_nettype none
module asbc_host (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire asbc_pkg::asbc_req_t req,
    output logic req_ready,
    output logic rd_valid,
    output logic [asbc_pkg::DATA_W-1:0] rd_data,
    output logic wr_done,
    output asbc_pkg::asbc_ctl_t mem_ctl,
    output logic [asbc_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [asbc_pkg::DATA_W-1:0] mem_data_in,
    output logic [asbc_pkg::DATA_W-1:0] mem_data_out,
    output logic mem_data_oe
);
    typedef enum logic [2:0] {
        S_IDLE, S_RD, S_RD_END, S_WR_SETUP, S_WR, S_WR_END
    } asbc_state_t;

    asbc_state_t state_q, state_d;
    logic [asbc_pkg::CNT_W-1:0] cnt_q, cnt_d;
    asbc_pkg::asbc_ctl_t ctl_q, ctl_d;
    logic [asbc_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [asbc_pkg::DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
    logic oe_q, oe_d, rdy_q, rdy_d, rdv_q, rdv_d, wrd_q, wrd_d;
    logic [asbc_pkg::DATA_W-1:0] sync1_q, sync2_q;

    // pins come from an asynchronous part: two flops before use
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sync1_q <= asbc_pkg::DATA_RST;
            sync2_q <= asbc_pkg::DATA_RST;
        end else begin
            sync1_q <= mem_data_in;
            sync2_q <= sync1_q;
        end
    end

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        ctl_d = ctl_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        rdat_d = rdat_q;
        oe_d = oe_q;
        rdy_d = rdy_q;
        rdv_d = 1'b0;
        wrd_d = 1'b0;
        case (state_q)
            S_IDLE: begin
                if (req_valid && rdy_q) begin
                    rdy_d = 1'b0;
                    addr_d = req.addr;
                    cnt_d = asbc_pkg::CNT_RST;
                    if (req.write) begin
                        wdat_d = req.wdata;
                        // select first, output enable high so pins float
                        ctl_d = '{1'b0, 1'b1, 1'b1, 1'b1};
                        state_d = S_WR_SETUP;
                    end else begin
                        // address set a cycle before select would also work,
                        // but same-edge is allowed and saves a cycle
                        ctl_d = '{1'b0, 1'b1, 1'b1, 1'b0};
                        state_d = S_RD;
                    end
                end
            end
            S_RD: begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == 4'(asbc_pkg::RD_CYC - 1)) begin
                    rdat_d = sync2_q;
                    rdv_d = 1'b1;
                    ctl_d = asbc_pkg::CTL_IDLE;
                    cnt_d = asbc_pkg::CNT_RST;
                    state_d = S_RD_END;
                end
            end
            S_RD_END: begin
                // wait for memory outputs to float before any new cycle
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == 4'(asbc_pkg::OEF_CYC - 1)) begin
                    rdy_d = 1'b1;
                    state_d = S_IDLE;
                end
            end
            S_WR_SETUP: begin
                // memory pins already floating: start driving, strobe low
                oe_d = 1'b1;
                ctl_d.write_strobe_n = 1'b0;
                cnt_d = asbc_pkg::CNT_RST;
                state_d = S_WR;
            end
            S_WR: begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == 4'(asbc_pkg::WR_CYC - 1)) begin
                    // strobe rises first, select stays: data held past edge
                    ctl_d.write_strobe_n = 1'b1;
                    state_d = S_WR_END;
                end
            end
            S_WR_END: begin
                // deselect and release data one cycle after the ending edge
                ctl_d = asbc_pkg::CTL_IDLE;
                oe_d = 1'b0;
                wrd_d = 1'b1;
                rdy_d = 1'b1;
                state_d = S_IDLE;
            end
            default: begin
                ctl_d = asbc_pkg::CTL_IDLE;
                oe_d = 1'b0;
                rdy_d = 1'b1;
                state_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_q <= S_IDLE;
            cnt_q <= asbc_pkg::CNT_RST;
            ctl_q <= asbc_pkg::CTL_IDLE;
            addr_q <= asbc_pkg::ADDR_RST;
            wdat_q <= asbc_pkg::DATA_RST;
            rdat_q <= asbc_pkg::DATA_RST;
            oe_q <= 1'b0;
            rdy_q <= 1'b1;
            rdv_q <= 1'b0;
            wrd_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            ctl_q <= ctl_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
            oe_q <= oe_d;
            rdy_q <= rdy_d;
            rdv_q <= rdv_d;
            wrd_q <= wrd_d;
        end
    end

    assign req_ready = rdy_q;
    assign rd_valid = rdv_q;
    assign rd_data = rdat_q;
    assign wr_done = wrd_q;
    assign mem_ctl = ctl_q;
    assign mem_addr = addr_q;
    assign mem_data_out = wdat_q;
    assign mem_data_oe = oe_q;

    logic sel;
    assign sel = !ctl_q.select_active_low && ctl_q.select_active_high;

    sequence s_strobe_fall;
        sel && $fell(ctl_q.write_strobe_n);
    endsequence

    property p_read_strobe_high;
        @(posedge mclk) disable iff (!rst_b)
        !ctl_q.output_enable_n |-> ctl_q.write_strobe_n;
    endproperty
    a_read_strobe_high: assert property (p_read_strobe_high)
        else $error("strobe low during read");

    property p_no_drive_on_read;
        @(posedge mclk) disable iff (!rst_b)
        !ctl_q.output_enable_n |-> !oe_q;
    endproperty
    a_no_drive_on_read: assert property (p_no_drive_on_read)
        else $error("host drives while memory outputs on");

    property p_strobe_only_selected;
        @(posedge mclk) disable iff (!rst_b)
        !ctl_q.write_strobe_n |-> sel && oe_q;
    endproperty
    a_strobe_only_selected: assert property (p_strobe_only_selected)
        else $error("strobe low without select or data");

    property p_pulse_width;
        @(posedge mclk) disable iff (!rst_b)
        // one cycle of 50 ns already covers setup plus float time
        s_strobe_fall |-> (!ctl_q.write_strobe_n)[*1] ##1
            ctl_q.write_strobe_n;
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("write pulse wrong length");

    property p_data_hold;
        @(posedge mclk) disable iff (!rst_b)
        $rose(ctl_q.write_strobe_n) && oe_q |->
            $stable(wdat_q) && oe_q && sel;
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("write data changed at write end");

    property p_addr_with_select;
        @(posedge mclk) disable iff (!rst_b)
        sel |-> $stable(addr_q) || $rose(sel);
    endproperty
    a_addr_with_select: assert property (p_addr_with_select)
        else $error("address moved while selected");

    property p_wr_oe_high;
        @(posedge mclk) disable iff (!rst_b)
        $rose(oe_q) |-> ctl_q.output_enable_n && $past(ctl_q.output_enable_n);
    endproperty
    a_wr_oe_high: assert property (p_wr_oe_high)
        else $error("output enable low in write");

    localparam int RD_LAT = asbc_pkg::RD_CYC;

    property p_read_done;
        @(posedge mclk) disable iff (!rst_b)
        $fell(ctl_q.output_enable_n) |-> ##RD_LAT rd_valid;
    endproperty
    a_read_done: assert property (p_read_done)
        else $error("read data not returned");

    property p_deselect_release;
        @(posedge mclk) disable iff (!rst_b)
        $rose(ctl_q.write_strobe_n) |=> !sel && !oe_q && wr_done;
    endproperty
    a_deselect_release: assert property (p_deselect_release)
        else $error("write end sequence wrong");

    property p_select_pins;
        @(posedge mclk) disable iff (!rst_b)
        !sel |->
            ctl_q.write_strobe_n && ctl_q.output_enable_n && !oe_q;
    endproperty
    a_select_pins: assert property (p_select_pins)
        else $error("activity while deselected");
endmodule : asbc_host
`default_nettype wire

// File: asbc_mem_model.sv
// behavioural model of the static memory on the far side of the host
`default_nettype none
module asbc_mem_model #(
    parameter int DLY_NS = 5
) (
    input wire asbc_pkg::asbc_ctl_t ctl,
    input wire logic [asbc_pkg::ADDR_W-1:0] addr,
    input wire logic [asbc_pkg::DATA_W-1:0] din,
    input wire logic din_oe,
    output logic [asbc_pkg::DATA_W-1:0] dout,
    output logic clash
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:(1<<17)-1];
    logic [7:0] last = 8'h00;
    logic sel;
    logic wr;
    logic drive;
    initial begin
        clash = 1'b0;
        for (int i = 0; i < (1 << 17); i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end
    assign sel = ~ctl.select_active_low & ctl.select_active_high;
    assign wr = sel & ~ctl.write_strobe_n;
    // writes only in the strobe and select overlap, stored at its end
    always @(negedge wr) begin
        mem[addr] = din;
    end
    assign drive = sel & ctl.write_strobe_n & ~ctl.output_enable_n;
    always @* begin
        if (drive) begin
            last = mem[addr];
        end
    end
    // released pins show the inverse so stale data never passes
    assign #(DLY_NS) dout = drive ? mem[addr] : ~last;
    always @* begin
        if (drive && din_oe) begin
            clash = 1'b1;
        end
    end
endmodule : asbc_mem_model
`default_nettype wire

// File: async_sram_bus_protocol_bench.sv
// self-checking bench for the static memory host controller
`default_nettype none
module async_sram_bus_protocol_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    asbc_pkg::asbc_req_t req = '0;
    logic req_ready, rd_valid, wr_done, mem_data_oe, clash;
    logic [7:0] rd_data, mem_data_in, mem_data_out, q;
    logic [16:0] mem_addr;
    asbc_pkg::asbc_ctl_t mem_ctl;
    int failures = 0;
    int n_compared = 0;
    always #25 mclk = ~mclk;
    asbc_host i_dut (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .wr_done(wr_done), .mem_ctl(mem_ctl),
        .mem_addr(mem_addr), .mem_data_in(mem_data_in),
        .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));
    // slow answer, still inside the two-flop sampling window
    asbc_mem_model #(.DLY_NS(60)) i_mem (.ctl(mem_ctl), .addr(mem_addr),
        .din(mem_data_out), .din_oe(mem_data_oe), .dout(mem_data_in),
        .clash(clash));
    task automatic test_done;
        if (failures == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    task automatic cmp(input string nm, input logic [16:0] e, g);
        n_compared++;
        if (e !== g) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic xfer(input logic w, input logic [16:0] a,
        input logic [7:0] d, output logic [7:0] rq);
        int k;
        logic done, sel, ss, ws, pw;
        begin
            k = 0;
            done = 1'b0;
            ss = 1'b0;
            ws = 1'b0;
            pw = 1'b0;
            req_valid = 1'b1;
            req = '{write: w, addr: a, wdata: d};
            while (!done && k < 20) begin
                @(posedge mclk);
                done = req_ready;
                k++;
            end
            #1 req_valid = 1'b0;
            done = 1'b0;
            while (!done && k < 40) begin
                @(posedge mclk);
                #1 k++;
                sel = !mem_ctl.select_active_low && mem_ctl.select_active_high;
                if (sel && !ss) cmp("addr", a, mem_addr);
                ss |= sel;
                if (sel && !w) cmp("strobe", 1, mem_ctl.write_strobe_n);
                if (!mem_ctl.write_strobe_n) begin
                    ws = 1'b1;
                    cmp("oe_n", 1, mem_ctl.output_enable_n);
                    cmp("data_oe", 1, mem_data_oe);
                end
                if (pw && mem_ctl.write_strobe_n) begin
                    cmp("hold_sel", 1, sel);
                    cmp("hold_data", d, mem_data_out);
                end
                if (ws) cmp("wdata", d, mem_data_out);
                pw = !mem_ctl.write_strobe_n;
                done = w ? wr_done : rd_valid;
            end
            rq = rd_data;
            if (!done) begin
                failures++;
                test_done();
            end
            cmp("sel_seen", 1, ss);
            cmp("strobe_seen", w, ws);
        end
    endtask : xfer
    task automatic t_idle;
        cmp("ctl", asbc_pkg::CTL_IDLE, mem_ctl);
        cmp("oe", 0, mem_data_oe);
        cmp("ready", 1, req_ready);
    endtask : t_idle
    task automatic t_write_read;
        logic [16:0] at [4] = '{17'h00000, 17'h1ffff, 17'h0a5a5, 17'h12345};
        logic [7:0] dt [4] = '{8'hff, 8'h00, 8'ha5, 8'h3c};
        for (int i = 0; i < 4; i++) xfer(1'b1, at[i], dt[i], q);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, at[i], 8'h00, q);
            cmp("rdata", dt[i], q);
        end
    endtask : t_write_read
    task automatic t_unwritten;
        xfer(1'b0, 17'h00777, 8'h00, q);
        cmp("rdata", 8'h77 ^ 8'h5a, q);
    endtask : t_unwritten
    task automatic t_overwrite;
        xfer(1'b1, 17'h00100, 8'h11, q);
        xfer(1'b1, 17'h00100, 8'h96, q);
        xfer(1'b0, 17'h00100, 8'h00, q);
        cmp("rdata", 8'h96, q);
    endtask : t_overwrite
    initial begin
        repeat (16) @(posedge mclk);
        #1 rst_b = 1'b1;
        @(posedge mclk);
        #1 t_idle();
        t_write_read();
        t_unwritten();
        t_overwrite();
        repeat (3) @(posedge mclk);
        #1 t_idle();
        cmp("clash", 0, clash);
        test_done();
    end
endmodule : async_sram_bus_protocol_bench
`default_nettype wire
